// ---- logic/port_b_map.vh ----
`ifndef PORT_B_MAP_VH
`define PORT_B_MAP_VH

// register byte offsets
`define PB_OFS_OUT_DATA    8'h00
`define PB_OFS_DIRECTION   8'h04
`define PB_OFS_PATTERN_EN  8'h08
`define PB_OFS_FUNC_CTRL   8'h0c
`define PB_OFS_DMA_SELECT  8'h10
`define PB_OFS_PIN_LEVEL   8'h14

// reset values
`define PB_RST_OUT_DATA    8'h00
`define PB_RST_DIRECTION   8'h00
`define PB_RST_PATTERN_EN  8'h00
`define PB_RST_FUNC_CTRL   16'h0000
`define PB_RST_DMA_SELECT  16'h0000
// write-only direction register reads back as all ones
`define PB_DIRECTION_READ  8'hff

// func_ctrl field positions
`define PB_FC_TRIG_EN      0
`define PB_FC_CHIP_SEL_EN  1
`define PB_FC_COMB_MODE    2
`define PB_FC_COMP_B_EN    3
`define PB_FC_COMP_A_EN    4
`define PB_FC_B_OUT_EN     5
`define PB_FC_A_OUT_EN     6
`define PB_FC_PWM_MODE     7
`define PB_FC_B_CTRL_LSB   8
`define PB_FC_A_CTRL_LSB   12

// dma_select field positions, channel 1 adds the channel offset
`define PB_DS_A_HIGH       0
`define PB_DS_A_MID        1
`define PB_DS_A_LOW        2
`define PB_DS_B_HIGH       3
`define PB_DS_B_MID        4
`define PB_DS_CH1_OFS      8

// bus responses
`define PB_RESP_OKAY       2'b00
`define PB_RESP_SLVERR     2'b10

`endif

// ---- logic/pin_sync.v ----
`timescale 1ns/100ps
// two-stage synchroniser for asynchronous pin levels
module pin_sync #(
  parameter WIDTH = 8
) (
  input  wire             clk_sys,
  input  wire             reset,
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  // first stage is read only by the second stage
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always @(posedge clk_sys) begin
        if (reset) begin
          meta_q[i] <= 1'b0;
          sync_q[i] <= 1'b0;
        end else begin
          meta_q[i] <= async_in[i];
          sync_q[i] <= meta_q[i];
        end
      end
    end
  endgenerate

  assign sync_out = sync_q;

endmodule // pin_sync

// ---- logic/pin_select.v ----
`timescale 1ns/100ps
`include "port_b_map.vh"
// combinational pin function selection for the eight port pins
module pin_select (
  input  wire [7:0]  port_out_data,
  input  wire [7:0]  port_direction,
  input  wire [7:0]  pattern_enable_high_reg,
  input  wire [7:0]  pattern_outputs,
  input  wire [15:0] func_ctrl,
  input  wire        chip_select_7_n,
  input  wire        timer4_comp_b_out,
  input  wire        timer4_comp_a_out,
  input  wire        timer4_capture_compare_b_out,
  input  wire        timer4_capture_compare_a_out,
  output reg  [7:0]  pin_out_d,
  output reg  [7:0]  pin_oe_d
);

  wire       combination_mode     = func_ctrl[`PB_FC_COMB_MODE];
  wire       pwm_mode             = func_ctrl[`PB_FC_PWM_MODE];
  wire [2:0] b_ctrl               = func_ctrl[`PB_FC_B_CTRL_LSB +: 3];
  wire [2:0] a_ctrl               = func_ctrl[`PB_FC_A_CTRL_LSB +: 3];
  wire [7:0] gpio_out;
  wire       timer_b_drive;
  wire       timer_a_drive;

  // plain i/o: direction picks output, pattern enable picks source
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_gpio
      assign gpio_out[i] = pattern_enable_high_reg[i] ?
                           pattern_outputs[i] : port_out_data[i];
    end
  endgenerate

  // compare output when output enabled and a compare code is set
  assign timer_b_drive = func_ctrl[`PB_FC_B_OUT_EN] &
                         (combination_mode |
                          (~b_ctrl[2] & (b_ctrl[1:0] != 2'b00)));
  assign timer_a_drive = func_ctrl[`PB_FC_A_OUT_EN] &
                         (combination_mode | pwm_mode |
                          (~a_ctrl[2] & (a_ctrl[1:0] != 2'b00)));

  // peripheral functions override the plain i/o choice per pin
  always @* begin
    pin_out_d = gpio_out;
    pin_oe_d  = port_direction;
    if (func_ctrl[`PB_FC_CHIP_SEL_EN]) begin
      pin_out_d[6] = chip_select_7_n;
      pin_oe_d[6]  = 1'b1;
    end
    if (func_ctrl[`PB_FC_COMP_B_EN] & combination_mode) begin
      pin_out_d[5] = timer4_comp_b_out;
      pin_oe_d[5]  = 1'b1;
    end
    if (func_ctrl[`PB_FC_COMP_A_EN] & combination_mode) begin
      pin_out_d[4] = timer4_comp_a_out;
      pin_oe_d[4]  = 1'b1;
    end
    if (timer_b_drive) begin
      pin_out_d[3] = timer4_capture_compare_b_out;
      pin_oe_d[3]  = 1'b1;
    end
    if (timer_a_drive) begin
      pin_out_d[2] = timer4_capture_compare_a_out;
      pin_oe_d[2]  = 1'b1;
    end
  end

endmodule // pin_select

// ---- logic/port_b.v ----
// Contract
// - eight-bit read/write data register drives pins set as outputs
// - data read returns stored bit where direction bit is one
// - data read returns pin level where direction bit is zero
// - data register cleared by reset and during hardware standby
// - data register keeps its contents during software standby
// - pin 7: input, output, or pattern output 15 by direction and enable
// - pin 7 feeds dma channel 1 request under the enabled select codes
// - pin 7 also feeds converter trigger when trigger enable is one
// - pin 6 drives chip select 7 when enabled, else plain i/o/pattern
// - pin 6 feeds dma channel 0 request under the same select codes
// - pin 5 drives comparator b output when its enable and combination set
// - pin 4 drives comparator a output when its enable and combination set
// - pin 3 drives capture/compare b output under enable and control codes
// - pin 2 set by combination, enable, pwm, control, pattern, direction
// - direction one makes a plain output, zero a plain input
// - pin 2 feeds capture a input in normal mode with control top set
`timescale 1ns/100ps
`include "port_b_map.vh"
module port_b #(
  parameter ADDR_W = 8
) (
  input  wire              clk_sys,
  input  wire              reset,
  input  wire              hw_standby,
  input  wire              sw_standby,
  // axi4-lite slave
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output wire              s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output wire              s_axi_wready,
  output wire [1:0]        s_axi_bresp,
  output wire              s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire              s_axi_arvalid,
  output wire              s_axi_arready,
  output wire [31:0]       s_axi_rdata,
  output wire [1:0]        s_axi_rresp,
  output wire              s_axi_rvalid,
  input  wire              s_axi_rready,
  // port pins
  input  wire [7:0]        pin_in,
  output wire [7:0]        pin_out,
  output wire [7:0]        pin_oe,
  // peripheral sources
  input  wire [7:0]        pattern_outputs,
  input  wire              chip_select_7_n,
  input  wire              timer4_comp_b_out,
  input  wire              timer4_comp_a_out,
  input  wire              timer4_capture_compare_b_out,
  input  wire              timer4_capture_compare_a_out,
  // peripheral sinks
  output wire              dma_request_ch1_n,
  output wire              dma_request_ch0_n,
  output wire              converter_trigger_n,
  output wire              timer4_capture_compare_b_in,
  output wire              timer4_capture_compare_a_in
);

  // register state
  reg  [7:0]        port_out_data_q;
  reg  [7:0]        port_direction_q;
  reg  [7:0]        pattern_enable_q;
  reg  [15:0]       func_ctrl_q;
  reg  [15:0]       dma_select_q;

  // bus state
  reg               aw_held_q;
  reg  [ADDR_W-1:0] aw_addr_q;
  reg               w_held_q;
  reg  [31:0]       w_data_q;
  reg  [3:0]        w_strb_q;
  reg               bvalid_q;
  reg  [1:0]        bresp_q;
  reg               rvalid_q;
  reg  [31:0]       rdata_q;
  reg  [1:0]        rresp_q;

  // pin-facing registered outputs
  reg  [7:0]        pin_out_q;
  reg  [7:0]        pin_oe_q;
  reg               dma_req1_n_q;
  reg               dma_req0_n_q;
  reg               trig_n_q;
  reg               cap_b_q;
  reg               cap_a_q;

  wire [7:0]        pin_level;
  wire [7:0]        pin_out_d;
  wire [7:0]        pin_oe_d;
  wire [31:0]       wmask;
  wire              do_write;
  wire              init_regs;
  reg  [31:0]       rdata_d;
  reg  [1:0]        rresp_d;
  reg  [1:0]        bresp_d;

  // pin levels are asynchronous to clk_sys
  pin_sync #(
    .WIDTH    (8)
  ) u_pin_sync (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .async_in (pin_in),
    .sync_out (pin_level)
  );

  pin_select u_pin_select (
    .port_out_data                (port_out_data_q),
    .port_direction               (port_direction_q),
    .pattern_enable_high_reg      (pattern_enable_q),
    .pattern_outputs              (pattern_outputs),
    .func_ctrl                    (func_ctrl_q),
    .chip_select_7_n              (chip_select_7_n),
    .timer4_comp_b_out            (timer4_comp_b_out),
    .timer4_comp_a_out            (timer4_comp_a_out),
    .timer4_capture_compare_b_out (timer4_capture_compare_b_out),
    .timer4_capture_compare_a_out (timer4_capture_compare_a_out),
    .pin_out_d                    (pin_out_d),
    .pin_oe_d                     (pin_oe_d)
  );

  // enabled dma select code set, shared by both channels
  function dma_enabled;
    input [4:0] sel;
    begin
      dma_enabled = sel[`PB_DS_B_HIGH] &
                    (sel[`PB_DS_B_MID] |
                     (sel[`PB_DS_A_HIGH] & sel[`PB_DS_A_MID] &
                      ~sel[`PB_DS_A_LOW]));
    end
  endfunction

  // byte-lane mask from the held write strobes
  assign wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
                  {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};

  // write fires once address and data are both held and no response waits
  assign do_write  = aw_held_q & w_held_q & ~bvalid_q;
  // hardware standby clears like reset; writes are frozen in software standby
  assign init_regs = reset | hw_standby;

  assign s_axi_awready = ~aw_held_q & ~bvalid_q;
  assign s_axi_wready  = ~w_held_q & ~bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  // write address and data may arrive in either order
  always @(posedge clk_sys) begin
    if (reset) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= {ADDR_W{1'b0}};
      w_held_q  <= 1'b0;
      w_data_q  <= 32'h00000000;
      w_strb_q  <= 4'h0;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held_q <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (do_write) begin
        w_held_q <= 1'b0;
      end
    end
  end

  // write response decode: unmapped and read-only offsets answer slverr
  always @* begin
    case (aw_addr_q)
      `PB_OFS_OUT_DATA,
      `PB_OFS_DIRECTION,
      `PB_OFS_PATTERN_EN,
      `PB_OFS_FUNC_CTRL,
      `PB_OFS_DMA_SELECT: bresp_d = `PB_RESP_OKAY;
      default:            bresp_d = `PB_RESP_SLVERR;
    endcase
  end

  // response stays until the master takes it
  always @(posedge clk_sys) begin
    if (reset) begin
      bvalid_q <= 1'b0;
      bresp_q  <= `PB_RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q  <= bresp_d;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // register file; software standby writes are dropped so contents are retained
  always @(posedge clk_sys) begin
    if (init_regs) begin
      port_out_data_q  <= `PB_RST_OUT_DATA;
      port_direction_q <= `PB_RST_DIRECTION;
      pattern_enable_q <= `PB_RST_PATTERN_EN;
      func_ctrl_q      <= `PB_RST_FUNC_CTRL;
      dma_select_q     <= `PB_RST_DMA_SELECT;
    end else if (do_write & ~sw_standby) begin
      case (aw_addr_q)
        `PB_OFS_OUT_DATA:
          port_out_data_q <= (port_out_data_q & ~wmask[7:0]) |
                             (w_data_q[7:0] & wmask[7:0]);
        `PB_OFS_DIRECTION:
          port_direction_q <= (port_direction_q & ~wmask[7:0]) |
                              (w_data_q[7:0] & wmask[7:0]);
        `PB_OFS_PATTERN_EN:
          pattern_enable_q <= (pattern_enable_q & ~wmask[7:0]) |
                              (w_data_q[7:0] & wmask[7:0]);
        `PB_OFS_FUNC_CTRL:
          func_ctrl_q <= (func_ctrl_q & ~wmask[15:0]) |
                         (w_data_q[15:0] & wmask[15:0]);
        `PB_OFS_DMA_SELECT:
          dma_select_q <= (dma_select_q & ~wmask[15:0]) |
                          (w_data_q[15:0] & wmask[15:0]);
        default: begin
        end
      endcase
    end
  end

  // read mux; data read mixes stored bits and synchronised pin levels
  always @* begin
    rdata_d = 32'h00000000;
    rresp_d = `PB_RESP_OKAY;
    case (s_axi_araddr)
      `PB_OFS_OUT_DATA:
        rdata_d[7:0] = (port_out_data_q & port_direction_q) |
                       (pin_level & ~port_direction_q);
      `PB_OFS_DIRECTION:  rdata_d[7:0]  = `PB_DIRECTION_READ;
      `PB_OFS_PATTERN_EN: rdata_d[7:0]  = pattern_enable_q;
      `PB_OFS_FUNC_CTRL:  rdata_d[15:0] = func_ctrl_q;
      `PB_OFS_DMA_SELECT: rdata_d[15:0] = dma_select_q;
      `PB_OFS_PIN_LEVEL:  rdata_d[7:0]  = pin_level;
      default:            rresp_d       = `PB_RESP_SLVERR;
    endcase
  end

  // read data is captured at the address handshake and held until taken
  always @(posedge clk_sys) begin
    if (reset) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h00000000;
      rresp_q  <= `PB_RESP_OKAY;
    end else if (s_axi_arvalid & s_axi_arready) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rdata_d;
      rresp_q  <= rresp_d;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // registered pin drive; costs one cycle but keeps pins glitch free
  always @(posedge clk_sys) begin
    if (init_regs) begin
      pin_out_q <= 8'h00;
      pin_oe_q  <= 8'h00; // port comes up as inputs
    end else begin
      pin_out_q <= pin_out_d;
      pin_oe_q  <= pin_oe_d;
    end
  end

  // peripheral inputs taken from synchronised pins; idle levels when off
  always @(posedge clk_sys) begin
    if (init_regs) begin
      dma_req1_n_q <= 1'b1;
      dma_req0_n_q <= 1'b1;
      trig_n_q     <= 1'b1;
      cap_b_q      <= 1'b0;
      cap_a_q      <= 1'b0;
    end else begin
      dma_req1_n_q <= dma_enabled(dma_select_q[`PB_DS_CH1_OFS +: 5]) ?
                      pin_level[7] : 1'b1;
      dma_req0_n_q <= dma_enabled(dma_select_q[4:0]) ?
                      pin_level[6] : 1'b1;
      trig_n_q     <= func_ctrl_q[`PB_FC_TRIG_EN] ?
                      pin_level[7] : 1'b1;
      cap_b_q      <= (~func_ctrl_q[`PB_FC_COMB_MODE] &
                       ~func_ctrl_q[`PB_FC_PWM_MODE] &
                       func_ctrl_q[`PB_FC_B_CTRL_LSB + 2]) ?
                      pin_level[3] : 1'b0;
      cap_a_q      <= (~func_ctrl_q[`PB_FC_COMB_MODE] &
                       ~func_ctrl_q[`PB_FC_PWM_MODE] &
                       func_ctrl_q[`PB_FC_A_CTRL_LSB + 2]) ?
                      pin_level[2] : 1'b0;
    end
  end

  assign pin_out                     = pin_out_q;
  assign pin_oe                      = pin_oe_q;
  assign dma_request_ch1_n           = dma_req1_n_q;
  assign dma_request_ch0_n           = dma_req0_n_q;
  assign converter_trigger_n         = trig_n_q;
  assign timer4_capture_compare_b_in = cap_b_q;
  assign timer4_capture_compare_a_in = cap_a_q;

endmodule // port_b

// ---- testbench/board_model.sv ----
`timescale 1ns/100ps
// board side of the port pins
module board_model (
  input  wire [7:0] pin_out,
  input  wire [7:0] pin_oe,
  input  wire [7:0] ext_level,
  output wire [7:0] pin_in
);
  // a driven pin wins over the board's weak source, so reads see real level
  assign pin_in = (pin_out & pin_oe) | (ext_level & ~pin_oe);
endmodule // board_model

// ---- testbench/port_b_props.sv ----
`timescale 1ns/100ps
// bus handshake and pin path relations seen at the port_b ports
module port_b_props (
  input wire        clk_sys,
  input wire        reset,
  input wire        hw_standby,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [7:0]  pin_in,
  input wire [7:0]  pin_out,
  input wire [7:0]  pin_oe,
  input wire        dma_request_ch1_n,
  input wire        dma_request_ch0_n,
  input wire        converter_trigger_n,
  input wire        timer4_capture_compare_b_in
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // address and data taken together, then read address taken
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // response lands exactly one cycle after the held pair is committed
  wr_resp_a: assert property (wr_take |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response timing wrong");
  rd_resp_a: assert property (rd_take |=> s_axi_rvalid)
    else $error("read response timing wrong");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  wr_block_a: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("write taken early");
  rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken early");
  // pins go quiet while hardware standby holds
  hw_quiet_a: assert property (hw_standby |=>
    pin_oe == 8'h00 && pin_out == 8'h00)
    else $error("pins driven in standby");
  // sink outputs only follow the pin through three flops
  trig_pin_a: assert property (!converter_trigger_n |->
    !$past(pin_in[7], 3)) else $error("trigger without low pin");
  dma_one_a: assert property (!dma_request_ch1_n |->
    !$past(pin_in[7], 3)) else $error("ch1 request without low pin");
  dma_zero_a: assert property (!dma_request_ch0_n |->
    !$past(pin_in[6], 3)) else $error("ch0 request without low pin");
  cap_b_a: assert property (timer4_capture_compare_b_in |->
    $past(pin_in[3], 3)) else $error("capture b without high pin");
endmodule // port_b_props

bind port_b port_b_props props_i (.*);

// ---- testbench/port_b_data_and_pin_select_tb.sv ----
`timescale 1ns/100ps
`include "port_b_map.vh"
module port_b_data_and_pin_select_tb;
  logic        clk_sys = 1'b0, reset = 1'b1;
  logic        hw_standby = 1'b0, sw_standby = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire         s_axi_arready, s_axi_rvalid;
  wire [1:0]   s_axi_bresp, s_axi_rresp;
  wire [31:0]  s_axi_rdata;
  wire [7:0]   pin_in, pin_out, pin_oe;
  logic [7:0]  ext_level = 8'h00, pattern_outputs = 8'h00;
  logic        chip_select_7_n = 1'b0, timer4_comp_b_out = 1'b1;
  logic        timer4_comp_a_out = 1'b0, timer4_capture_compare_b_out = 1'b1;
  logic        timer4_capture_compare_a_out = 1'b0;
  wire         dma_request_ch1_n, dma_request_ch0_n, converter_trigger_n;
  wire         timer4_capture_compare_b_in, timer4_capture_compare_a_in;
  int          miscompares = 0, n_compared = 0, cycles = 0;
  logic [1:0]  resp;
  logic [31:0] rd;
  // rows: direction, data, board level, expected data read
  logic [31:0] rows [0:3] = '{32'hffa500a5, 32'h00a53c3c,
                              32'h0f96c3c6, 32'hf000ff0f};

  port_b uut (.*);
  board_model board (.*);

  initial forever #5 clk_sys = ~clk_sys;

  // a hung handshake must still reach the verdict
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      give_verdict();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    if (miscompares == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ready is looked at mid-cycle, so the next rising edge is the transfer
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    logic aw_done, w_done, ta, tw;
    aw_done = 0;
    w_done = 0;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(negedge clk_sys);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      @(posedge clk_sys);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      aw_done = aw_done | ta;
      w_done = w_done | tw;
    end
    do @(negedge clk_sys); while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    @(posedge clk_sys);
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] a);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge clk_sys); while (s_axi_arready !== 1'b1);
    @(posedge clk_sys);
    s_axi_arvalid <= 1'b0;
    do @(negedge clk_sys); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    @(posedge clk_sys);
    s_axi_rready <= 1'b0;
  endtask

  // config then wait out the three-flop pin path before looking
  task automatic cfg(input logic [7:0] a, input logic [31:0] d);
    axi_write(a, d);
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask

  initial begin
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    @(negedge clk_sys);
    check(pin_oe, 8'h00);
    check({dma_request_ch1_n, dma_request_ch0_n, converter_trigger_n},
          3'b111);
    axi_read(`PB_OFS_OUT_DATA);
    check(rd, 32'h0);
    axi_read(`PB_OFS_DIRECTION);
    check(rd, {24'h0, `PB_DIRECTION_READ});
    axi_read(8'h40);
    check(resp, `PB_RESP_SLVERR);
    axi_write(`PB_OFS_PIN_LEVEL, 32'h0);
    check(resp, `PB_RESP_SLVERR);
    // ordinary cases
    for (int i = 0; i < 4; i++) begin
      ext_level <= rows[i][15:8];
      axi_write(`PB_OFS_DIRECTION, {24'h0, rows[i][31:24]});
      cfg(`PB_OFS_OUT_DATA, {24'h0, rows[i][23:16]});
      axi_read(`PB_OFS_OUT_DATA);
      check(rd, {24'h0, rows[i][7:0]});
      check(pin_oe, rows[i][31:24]);
      check(pin_out & pin_oe, rows[i][23:16] & rows[i][31:24]);
    end
    // software standby drops writes, data keeps its value
    axi_write(`PB_OFS_OUT_DATA, 32'h5a);
    @(posedge clk_sys) sw_standby <= 1'b1;
    axi_write(`PB_OFS_OUT_DATA, 32'hff);
    check(resp, `PB_RESP_OKAY);
    @(posedge clk_sys) sw_standby <= 1'b0;
    axi_read(`PB_OFS_OUT_DATA);
    check(rd, 32'h5f);
    // hardware standby clears data; direction is then set to ones to read it back
    @(posedge clk_sys) hw_standby <= 1'b1;
    @(posedge clk_sys) hw_standby <= 1'b0;
    axi_write(`PB_OFS_DIRECTION, 32'hff);
    axi_read(`PB_OFS_OUT_DATA);
    check(rd, 32'h0);
    // pattern outputs replace the data on output pins
    pattern_outputs <= 8'ha5;
    cfg(`PB_OFS_PATTERN_EN, 32'hff);
    check(pin_out, 8'ha5);
    // alternate outputs override direction zero
    axi_write(`PB_OFS_DIRECTION, 32'h00);
    cfg(`PB_OFS_FUNC_CTRL, 32'h007e);
    check(pin_oe[6:2], 5'b11111);
    check(pin_out[6:2], 5'b01010);
    cfg(`PB_OFS_FUNC_CTRL, 32'h1160);
    check(pin_oe[3:2], 2'b11);
    @(posedge clk_sys) ext_level <= 8'h0c;
    cfg(`PB_OFS_FUNC_CTRL, 32'h4460);
    check(pin_oe[3:2], 2'b00);
    check({timer4_capture_compare_b_in, timer4_capture_compare_a_in},
          2'b11);
    // pulse-width mode drives pin 2 and masks both capture inputs
    cfg(`PB_OFS_FUNC_CTRL, 32'h44c0);
    check(pin_oe[3:2], 2'b01);
    check({timer4_capture_compare_b_in, timer4_capture_compare_a_in},
          2'b00);
    // request and trigger paths from low pins 7 and 6
    @(posedge clk_sys) ext_level <= 8'h00;
    axi_write(`PB_OFS_FUNC_CTRL, 32'h0001);
    cfg(`PB_OFS_DMA_SELECT, 32'h0b18);
    check({dma_request_ch1_n, dma_request_ch0_n}, 2'b00);
    check(converter_trigger_n, 1'b0);
    cfg(`PB_OFS_DMA_SELECT, 32'h0f00);
    check({dma_request_ch1_n, dma_request_ch0_n}, 2'b11);
    give_verdict();
  end
endmodule // port_b_data_and_pin_select_tb
